// file: cso_defines.svh
// Purpose: Offsets, reset values and widths of the output statistics counter bank.
// Assumes: Byte-wide registers on an 8-bit register address space.
// Notes: Definitions only; included by bare name.
`ifndef CSO_DEFINES_SVH
`define CSO_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets, high byte of each pair; the low byte sits at offset + 1.
`define CSO_PORT0_FRAME_COUNT_HIGH_OFS 8'h90
`define CSO_PORT0_FRAME_COUNT_LOW_OFS 8'h91
`define CSO_PORT0_ERRORED_FRAME_COUNT_HIGH_OFS 8'h92
`define CSO_PORT0_ERRORED_FRAME_COUNT_LOW_OFS 8'h93
`define CSO_PORT0_LINE_COUNT_HIGH_OFS 8'h94
`define CSO_PORT0_LINE_COUNT_LOW_OFS 8'h95
`define CSO_PORT0_ERRORED_LINE_COUNT_HIGH_OFS 8'h96
`define CSO_PORT0_ERRORED_LINE_COUNT_LOW_OFS 8'h97
`define CSO_PORT1_FRAME_COUNT_HIGH_OFS 8'h98
`define CSO_PORT1_FRAME_COUNT_LOW_OFS 8'h99

////////////////////////////////////////////////////////////////////////////////
// Field positions and widths.
`define CSO_ADDR_W 8
`define CSO_DATA_W 8
`define CSO_COUNT_W 16
`define CSO_HIGH_MSB 15
`define CSO_HIGH_LSB 8
`define CSO_LOW_MSB 7
`define CSO_LOW_LSB 0
`define CSO_NUM_COUNTERS 5

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define CSO_COUNT_RESET 16'h0000
`define CSO_BYTE_RESET 8'h00
`define CSO_UNMAPPED_DATA 8'h00

`endif

// file: cso_pkg.sv
// Purpose: Types shared by the output statistics counter bank.
// Assumes: Offsets and widths come from cso_defines.svh.
// Notes: Counter order matches the register order in the map.
`include "cso_defines.svh"

package cso_pkg;

	// Which statistics counter a register pair belongs to.
	typedef enum logic [2:0] {
		CSO_CTR_P0_FRAME = 3'h0,
		CSO_CTR_P0_ERR_FRAME = 3'h1,
		CSO_CTR_P0_LINE = 3'h2,
		CSO_CTR_P0_ERR_LINE = 3'h3,
		CSO_CTR_P1_FRAME = 3'h4
	} cso_ctr_t;

	typedef logic [`CSO_COUNT_W-1:0] cso_count_t;
	typedef logic [`CSO_DATA_W-1:0] cso_byte_t;
	typedef logic [`CSO_ADDR_W-1:0] cso_addr_t;

	// Read port sequencing: waiting, or presenting a read answer.
	typedef enum logic [1:0] {
		CSO_RD_IDLE = 2'b01,
		CSO_RD_ANSWER = 2'b10
	} cso_rd_state_t;

endpackage

// file: cso_stat_counter.sv
// Purpose: One 16-bit statistics counter with its held low byte.
// Assumes: Event and clear are one-cycle pulses on the core clock.
// Notes: The counter wraps from 0xffff to zero.
`timescale 1ns/1ns
`include "cso_defines.svh"

module cso_stat_counter
	import cso_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic event_i,
	input wire logic snap_clear_i,
	output cso_count_t count_o,
	output cso_byte_t low_hold_o
);

	cso_count_t count_q;
	cso_count_t count_d;
	cso_byte_t low_hold_q;
	cso_byte_t low_hold_d;

	////////////////////////////////////////////////////////////////////////////////
	// A snapshot copies the low byte before the clear, and an event in the same
	// cycle as the clear is kept as the first count of the new interval.
	always_comb begin
		count_d = count_q;
		low_hold_d = low_hold_q;
		if (snap_clear_i) begin
			low_hold_d = count_q[`CSO_LOW_MSB:`CSO_LOW_LSB];
			count_d = event_i ? cso_count_t'(1) : `CSO_COUNT_RESET;
		end else if (event_i) begin
			count_d = count_q + cso_count_t'(1);
		end
	end

	// Both values come up as zero after reset.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_q <= `CSO_COUNT_RESET;
			low_hold_q <= `CSO_BYTE_RESET;
		end else begin
			count_q <= count_d;
			low_hold_q <= low_hold_d;
		end
	end

	assign count_o = count_q;
	assign low_hold_o = low_hold_q;

endmodule

// file: cso_stat_bank.sv
// Purpose: Statistics counters of the two CSI-2 output ports, read as byte pairs.
// Assumes: Register reads arrive from the control-bus slave on the core clock as
//          a one-cycle strobe with an address; counter events come from the
//          CSI-2 transmitters on the same clock.
// Notes: Registers are read only; writes to this range have no effect.
`timescale 1ns/1ns
`include "cso_defines.svh"

module cso_stat_bank
	import cso_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic rd_req_i,
	input wire cso_addr_t rd_addr_i,
	input wire logic port0_frame_i,
	input wire logic port0_errored_frame_i,
	input wire logic port0_line_i,
	input wire logic port0_errored_line_i,
	input wire logic port1_frame_i,
	output cso_byte_t rd_data_o,
	output logic rd_valid_o,
	output logic rd_hit_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release.

	logic rst_meta_q;
	logic rst_sync_q;

	// The reset asserts at once but leaves on a clock edge, so no counter sees
	// a release that lands close to an edge.
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.

	// High-byte offsets of the five pairs, in counter order.
	localparam cso_addr_t HIGH_OFS [`CSO_NUM_COUNTERS] = '{
		`CSO_PORT0_FRAME_COUNT_HIGH_OFS,
		`CSO_PORT0_ERRORED_FRAME_COUNT_HIGH_OFS,
		`CSO_PORT0_LINE_COUNT_HIGH_OFS,
		`CSO_PORT0_ERRORED_LINE_COUNT_HIGH_OFS,
		`CSO_PORT1_FRAME_COUNT_HIGH_OFS
	};

	// Low-byte offsets of the five pairs, in counter order.
	localparam cso_addr_t LOW_OFS [`CSO_NUM_COUNTERS] = '{
		`CSO_PORT0_FRAME_COUNT_LOW_OFS,
		`CSO_PORT0_ERRORED_FRAME_COUNT_LOW_OFS,
		`CSO_PORT0_LINE_COUNT_LOW_OFS,
		`CSO_PORT0_ERRORED_LINE_COUNT_LOW_OFS,
		`CSO_PORT1_FRAME_COUNT_LOW_OFS
	};

	logic [`CSO_NUM_COUNTERS-1:0] ctr_event;
	logic [`CSO_NUM_COUNTERS-1:0] high_sel;
	logic [`CSO_NUM_COUNTERS-1:0] low_sel;
	logic [`CSO_NUM_COUNTERS-1:0] snap_clear;
	cso_count_t ctr_count [`CSO_NUM_COUNTERS];
	cso_byte_t ctr_low [`CSO_NUM_COUNTERS];

	// Event inputs in counter order; they share the core clock, so no
	// synchroniser sits in front of them.
	assign ctr_event[CSO_CTR_P0_FRAME] = port0_frame_i;
	assign ctr_event[CSO_CTR_P0_ERR_FRAME] = port0_errored_frame_i;
	assign ctr_event[CSO_CTR_P0_LINE] = port0_line_i;
	assign ctr_event[CSO_CTR_P0_ERR_LINE] = port0_errored_line_i;
	assign ctr_event[CSO_CTR_P1_FRAME] = port1_frame_i;

	////////////////////////////////////////////////////////////////////////////////
	// Counter channels.

	// Only a read of a high byte snapshots and clears; a low-byte read has no
	// side effect, so it may be repeated freely.
	for (genvar g = 0; g < `CSO_NUM_COUNTERS; g++) begin : g_ctr
		assign high_sel[g] = (rd_addr_i == HIGH_OFS[g]);
		assign low_sel[g] = (rd_addr_i == LOW_OFS[g]);
		assign snap_clear[g] = rd_req_i && high_sel[g];

		cso_stat_counter u_ctr (
			.clk_i(sys_clk_i),
			.rst_n_i(rst_sync_q),
			.event_i(ctr_event[g]),
			.snap_clear_i(snap_clear[g]),
			.count_o(ctr_count[g]),
			.low_hold_o(ctr_low[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data selection.

	cso_byte_t rd_mux;
	logic rd_mux_hit;

	// A high read answers with the live upper byte in the same edge that clears
	// the counter, so the byte and the snapshot belong to one count value.
	// Unmapped addresses answer zero.
	always_comb begin
		rd_mux = `CSO_UNMAPPED_DATA;
		rd_mux_hit = 1'b0;
		for (int i = 0; i < `CSO_NUM_COUNTERS; i++) begin
			if (high_sel[i]) begin
				rd_mux = ctr_count[i][`CSO_HIGH_MSB:`CSO_HIGH_LSB];
				rd_mux_hit = 1'b1;
			end
			if (low_sel[i]) begin
				rd_mux = ctr_low[i];
				rd_mux_hit = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read answer sequencing.

	cso_rd_state_t rd_state_q;
	cso_rd_state_t rd_state_d;
	cso_byte_t rd_data_q;
	cso_byte_t rd_data_d;
	logic rd_hit_q;
	logic rd_hit_d;

	// Each request is answered on the next cycle; a request in the answer cycle
	// is taken too, so reads may follow back to back. The low register only
	// matches the high byte if software keeps the high-then-low order.
	always_comb begin
		rd_state_d = rd_state_q;
		rd_data_d = rd_data_q;
		rd_hit_d = rd_hit_q;
		unique case (rd_state_q)
			CSO_RD_IDLE: begin
				if (rd_req_i) begin
					rd_state_d = CSO_RD_ANSWER;
					rd_data_d = rd_mux;
					rd_hit_d = rd_mux_hit;
				end
			end
			CSO_RD_ANSWER: begin
				if (rd_req_i) begin
					rd_data_d = rd_mux;
					rd_hit_d = rd_mux_hit;
				end else begin
					rd_state_d = CSO_RD_IDLE;
				end
			end
			default: begin
				rd_state_d = CSO_RD_IDLE;
			end
		endcase
	end

	// The data byte keeps its value after the answer cycle so a slow control
	// bus shifter may sample it late.
	always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rd_state_q <= CSO_RD_IDLE;
			rd_data_q <= `CSO_BYTE_RESET;
			rd_hit_q <= 1'b0;
		end else begin
			rd_state_q <= rd_state_d;
			rd_data_q <= rd_data_d;
			rd_hit_q <= rd_hit_d;
		end
	end

	assign rd_data_o = rd_data_q;
	// The answer state is one-hot, so its own bit is the valid flag straight from a flop.
	assign rd_valid_o = rd_state_q[1];
	assign rd_hit_o = rd_hit_q;

endmodule

// file: cso_stat_bank_sva.sv
// Purpose: Port-level checks of the output statistics counter bank.
// Assumes: One clock; reads follow the one-cycle answer contract.
// Notes: Bound to every cso_stat_bank instance.
`timescale 1ns/1ns
module cso_stat_bank_sva
	import cso_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic rd_req_i,
	input wire cso_addr_t rd_addr_i,
	input wire logic port0_frame_i,
	input wire logic port0_errored_frame_i,
	input wire logic port0_line_i,
	input wire logic port0_errored_line_i,
	input wire logic port1_frame_i,
	input wire cso_byte_t rd_data_o,
	input wire logic rd_valid_o,
	input wire logic rd_hit_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	// A high read with no event at its edge leaves the counter at zero.
	sequence s_hi(a, ev);
		rd_req_i && rd_addr_i == a && !ev;
	endsequence
	property p_clr(a, ev);
		s_hi(a, ev) ##1 rd_req_i && rd_addr_i == a |=> rd_data_o == 8'h00;
	endproperty
	a_answer_next: assert property (rd_req_i |=> rd_valid_o) else $error("no answer");
	a_no_spurious: assert property (!rd_req_i |=> !rd_valid_o) else $error("stray valid");
	a_data_holds: assert property (!rd_req_i |=> $stable(rd_data_o)) else $error("data moved");
	a_mapped_hit: assert property (rd_req_i && rd_addr_i inside {[8'h90:8'h99]} |=> rd_hit_o)
		else $error("hit missing");
	a_unmapped_zero: assert property (rd_req_i && !(rd_addr_i inside {[8'h90:8'h99]})
		|=> !rd_hit_o && rd_data_o == 8'h00) else $error("unmapped answer");
	a_p0f_clear: assert property (p_clr(8'h90, port0_frame_i)) else $error("no clear");
	a_p0ef_clear: assert property (p_clr(8'h92, port0_errored_frame_i)) else $error("no clear");
	a_p0l_clear: assert property (p_clr(8'h94, port0_line_i)) else $error("no clear");
	a_p0el_clear: assert property (p_clr(8'h96, port0_errored_line_i)) else $error("no clear");
	a_p1f_clear: assert property (p_clr(8'h98, port1_frame_i)) else $error("no clear");
endmodule
bind cso_stat_bank cso_stat_bank_sva u_sva (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
	.rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .port0_frame_i(port0_frame_i),
	.port0_errored_frame_i(port0_errored_frame_i), .port0_line_i(port0_line_i),
	.port0_errored_line_i(port0_errored_line_i), .port1_frame_i(port1_frame_i),
	.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_hit_o(rd_hit_o));

// file: cso_host_model.sv
// Purpose: Host reading the counter bank through the read strobe.
// Assumes: Requests change one tick after a rising edge.
// Notes: A released address shows its inverse, never the last value.
`timescale 1ns/1ns
module cso_host_model
	import cso_pkg::*;
(
	input wire logic clk_i,
	output logic req_o,
	output cso_addr_t addr_o
);
	initial begin
		req_o = 1'b0;
		addr_o = 8'h00;
	end
	// Two reads on consecutive edges; high then low keeps the snapshot coherent.
	task automatic pair(input cso_addr_t a, input cso_addr_t b);
		@(posedge clk_i);
		#1;
		req_o = 1'b1;
		addr_o = a;
		@(posedge clk_i);
		#1;
		addr_o = b;
		@(posedge clk_i);
		#1;
		req_o = 1'b0;
		addr_o = ~b;
	endtask
endmodule

// file: test_csi_output_stat_counters.sv
// Purpose: Random and corner traffic against a byte-pair counter model.
// Assumes: Events and reads change one tick after the rising edge.
// Notes: The model predicts every answer one cycle ahead.
`timescale 1ns/1ns
module test_csi_output_stat_counters;
	import cso_pkg::*;
	logic sys_clk_i, arst_n_i, rd_req_i, rd_valid_o, rd_hit_o, ev_on, exp_v, exp_h;
	cso_addr_t rd_addr_i, hi;
	cso_byte_t rd_data_o, exp_d;
	logic [4:0] ev, clr;
	cso_count_t cnt [5];
	cso_byte_t hold [5];
	logic [31:0] lfsr;
	int num_errors, n_compared, k;
	cso_stat_bank DUT (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .rd_req_i(rd_req_i),
		.rd_addr_i(rd_addr_i), .port0_frame_i(ev[0]), .port0_errored_frame_i(ev[1]),
		.port0_line_i(ev[2]), .port0_errored_line_i(ev[3]), .port1_frame_i(ev[4]),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_hit_o(rd_hit_o));
	cso_host_model host (.clk_i(sys_clk_i), .req_o(rd_req_i), .addr_o(rd_addr_i));
	always #10 sys_clk_i = ~sys_clk_i;
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task summarize;
		$display("compares %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Model: outputs seen here were launched by the previous edge, inputs are settled.
	always @(posedge sys_clk_i) begin
		if (exp_v) chk("rd_data_o", exp_d, rd_data_o);
		if (exp_v) chk("rd_hit_o", {7'h00, exp_h}, {7'h00, rd_hit_o});
		if (arst_n_i) chk("rd_valid_o", {7'h00, exp_v}, {7'h00, rd_valid_o});
		exp_v = arst_n_i && rd_req_i;
		exp_h = exp_v && rd_addr_i >= 8'h90 && rd_addr_i <= 8'h99;
		exp_d = 8'h00;
		clr = 5'h00;
		if (exp_h) begin
			k = (rd_addr_i - 8'h90) >> 1;
			if (rd_addr_i[0]) exp_d = hold[k];
			else begin
				exp_d = cnt[k][15:8];
				hold[k] = cnt[k][7:0];
				clr[k] = 1'b1;
			end
		end
		for (int i = 0; i < 5; i++) begin
			cnt[i] = clr[i] ? 16'(ev[i]) : cnt[i] + 16'(ev[i]);
			if (!arst_n_i) cnt[i] = 16'h0000;
			if (!arst_n_i) hold[i] = 8'h00;
		end
	end
	// Event pulses come from the shift register one tick after each edge.
	always @(posedge sys_clk_i) begin
		#1;
		lfsr = nxt(lfsr);
		ev = ev_on ? lfsr[4:0] & lfsr[9:5] : 5'h00;
	end
	initial begin
		#400000;
		num_errors++;
		summarize;
	end
	initial begin
		sys_clk_i = 1'b0;
		arst_n_i = 1'b0;
		ev = 5'h00;
		ev_on = 1'b0;
		exp_v = 1'b0;
		lfsr = 32'h31f4;
		repeat (2) @(posedge sys_clk_i);
		#1 arst_n_i = 1'b1;
		repeat (2) @(posedge sys_clk_i);
		for (int a = 8'h8c; a <= 8'h9b; a += 2) host.pair(8'(a), 8'(a + 1));
		$display("test reset_values done");
		ev_on = 1'b1;
		repeat (600) begin
			hi = 8'h90 + 8'((lfsr[18:16] % 5) * 2);
			if (lfsr[20]) host.pair(hi, hi + 8'h01);
			else host.pair(8'h8c + 8'(lfsr[24:21]), hi);
		end
		$display("test random_traffic done");
		ev_on = 1'b0;
		for (int i = 0; i < 5; i++) host.pair(8'h90 + 8'(2 * i), 8'h90 + 8'(2 * i));
		$display("test clear_back_to_back done");
		repeat (3) @(posedge sys_clk_i);
		summarize;
	end
endmodule
